// ==== hdl/pin_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync
	import sup_pkg::*;
#(
	parameter int         W       = SY_W,
	parameter logic [4:0] RST_VAL = SY_RST
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         srst,
	// pins in, synchronised copies out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_sync;

	// per-bit stage selection; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign nxt_meta[i] = srst ? RST_VAL[i] : async_in[i];
		assign nxt_sync[i] = srst ? RST_VAL[i] : meta_ff[i];
	end

	always_ff @(posedge ref_clk) begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	assign sync_out = sync_ff;

endmodule : pin_sync

// ==== hdl/sup_pkg.sv ====
// constants and types shared by the supervisor design
package sup_pkg;

	// time base
	localparam int unsigned CLK_HZ     = 50_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// times in milliseconds, as specified
	localparam int unsigned POR_MS      = 200;
	localparam int unsigned WD_LONG_MS  = 1400;
	localparam int unsigned WD_MID_MS   = 600;
	localparam int unsigned WD_SHORT_MS = 200;
	localparam int unsigned NVW_MS      = 5;

	// derived cycle counts, defaults of the top-level parameters
	localparam int unsigned POR_CYC_DEF      = POR_MS * CYC_PER_MS;
	localparam int unsigned WD_LONG_CYC_DEF  = WD_LONG_MS * CYC_PER_MS;
	localparam int unsigned WD_MID_CYC_DEF   = WD_MID_MS * CYC_PER_MS;
	localparam int unsigned WD_SHORT_CYC_DEF = WD_SHORT_MS * CYC_PER_MS;
	localparam int unsigned NVW_CYC_DEF      = NVW_MS * CYC_PER_MS;

	// serial instruction opcodes
	localparam logic [7:0] OP_SET_FLAG = 8'h00;
	localparam logic [7:0] OP_WRSR     = 8'h01;
	localparam logic [7:0] OP_WRITE    = 8'h02;
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_CLR      = 8'h04;
	localparam logic [7:0] OP_RDSR     = 8'h05;
	localparam logic [7:0] OP_WREN     = 8'h06;

	// status byte field positions
	localparam int ST_PROTECT_LOCK_ENABLE_BIT  = 7;
	localparam int ST_FLAG  = 6;
	localparam int ST_WD_HI = 5;
	localparam int ST_WD_LO = 4;
	localparam int ST_BL_HI = 3;
	localparam int ST_BL_LO = 2;

	// timeout select encodings
	localparam logic [1:0] WD_SEL_LONG  = 2'h0;
	localparam logic [1:0] WD_SEL_MID   = 2'h1;
	localparam logic [1:0] WD_SEL_SHORT = 2'h2;
	localparam logic [1:0] WD_SEL_OFF   = 2'h3;

	// reset values of the nonvolatile bits (factory state)
	localparam logic [1:0] WD_SEL_RST = WD_SEL_OFF;
	localparam logic [1:0] BL_RST     = 2'h0;
	localparam logic       PROTECT_LOCK_ENABLE_BIT_RST   = 1'b0;

	// serial bit counter
	localparam logic [2:0] BIT_LAST = 3'h7;

	// synchroniser input order
	localparam int SY_CS   = 0;
	localparam int SY_SCK  = 1;
	localparam int SY_SI   = 2;
	localparam int SY_WP   = 3;
	localparam int SY_LOW  = 4;
	localparam int SY_W    = 5;
	localparam logic [4:0] SY_RST = 5'h09;

	typedef enum logic [2:0] {
		SER_IDLE,
		SER_OPCODE,
		SER_WRDATA,
		SER_RDOUT,
		SER_IGNORE
	} ser_state_t;

endpackage : sup_pkg

// ==== hdl/sup_watchdog.sv ====
// processor supervisor: reset generator, watchdog and serial status port
//
// Overview of operation
// [R1] select high deselects and floats the serial output; low enables the device
// [R2] host must give a select falling edge after power-up before any operation
// [R3] deselected and no nonvolatile write busy means standby; busy write stays active
// [R4] every select falling edge restarts the watchdog count from zero
// [R5] no falling edge within the selected timeout drives reset active
// [R6] watchdog resets only when enabled, whether select sits high or low
// [R7] host must pulse select low periodically before each timeout
// [R8] two nonvolatile status bits choose the watchdog period
// [R9] protect pin low with lock bit set freezes watchdog, lock and protect bits
// [R10] supply below threshold asserts reset until 200 ms of good supply
// [R11] reset is asserted at power-up and held 200 ms after supply is good
// [R12] while reset is active all serial instructions are ignored
// [R13] serial input sampled on clock rising edges, most significant bit first
// [R14] read data changes on serial clock falling edges, push-pull output
// [R15] select 00 is 1.4 s, 01 600 ms, 10 200 ms, 11 disabled
// [R16] volatile cause flag set and cleared by command, cleared at power-up
// [R17] after a watchdog reset is released the count restarts from zero
`timescale 1ns/10ps
module sup_watchdog
	import sup_pkg::*;
#(
	parameter int unsigned POR_CYCLES      = POR_CYC_DEF,
	parameter int unsigned WD_LONG_CYCLES  = WD_LONG_CYC_DEF,
	parameter int unsigned WD_MID_CYCLES   = WD_MID_CYC_DEF,
	parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC_DEF,
	parameter int unsigned NVW_CYCLES      = NVW_CYC_DEF
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic srst,
	// host serial pins
	input  wire logic select_and_kick_input_n,
	input  wire logic sck,
	input  wire logic si,
	output logic      so_out,
	output logic      so_oe,
	// protect pin and supply monitor
	input  wire logic write_protect_n,
	input  wire logic supply_low,
	// supervisor outputs
	output logic      reset_out,
	output logic      standby,
	output logic      reset_cause_flag,
	output logic      timeout_select_high_bit,
	output logic      timeout_select_low_bit
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and edge detection

	logic [SY_W-1:0] pins_s;
	logic            cs_s;
	logic            sck_s;
	logic            si_s;
	logic            wp_n_s;
	logic            low_s;
	logic            cs_prev_ff;
	logic            sck_prev_ff;
	logic            cs_fall;
	logic            cs_rise;
	logic            sck_rise;
	logic            sck_fall;

	pin_sync #(
		.W       (SY_W),
		.RST_VAL (SY_RST)
	) u_sync (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.async_in ({supply_low, write_protect_n, si, sck, select_and_kick_input_n}),
		.sync_out (pins_s)
	);

	assign cs_s   = pins_s[SY_CS];
	assign sck_s  = pins_s[SY_SCK];
	assign si_s   = pins_s[SY_SI];
	assign wp_n_s = pins_s[SY_WP];
	assign low_s  = pins_s[SY_LOW];

	// previous levels, idle high select so reset never fakes an edge
	always_ff @(posedge ref_clk) begin
		cs_prev_ff  <= srst ? 1'b1 : cs_s;
		sck_prev_ff <= srst ? 1'b0 : sck_s;
	end

	assign cs_fall  = cs_prev_ff & ~cs_s;
	assign cs_rise  = ~cs_prev_ff & cs_s;
	assign sck_rise = ~sck_prev_ff & sck_s;
	assign sck_fall = sck_prev_ff & ~sck_s;

	////////////////////////////////////////////////////////////////////////////
	// reset generator and watchdog

	logic [31:0] rst_cnt_ff;
	logic [31:0] nxt_rst_cnt;
	logic [31:0] wd_cnt_ff;
	logic [31:0] nxt_wd_cnt;
	logic        reset_out_ff;
	logic        nxt_reset_out;
	logic        rst_act;
	logic        wd_en;
	logic        wd_expire;
	logic [1:0]  wd_sel_ff;

	// timeout decode, used only by the expiry compare
	function automatic logic [31:0] wd_period(input logic [1:0] sel);
		unique case (sel)
			WD_SEL_LONG:  wd_period = WD_LONG_CYCLES;   // R15
			WD_SEL_MID:   wd_period = WD_MID_CYCLES;    // R15
			WD_SEL_SHORT: wd_period = WD_SHORT_CYCLES;  // R15
			WD_SEL_OFF:   wd_period = '0;
		endcase
	endfunction : wd_period

	assign rst_act   = (rst_cnt_ff != POR_CYCLES);
	assign wd_en     = (wd_sel_ff != WD_SEL_OFF);  // R6 R8
	// a level held either way never kicks, only a falling edge does
	assign wd_expire = wd_en && !rst_act && !cs_fall
		&& (wd_cnt_ff == wd_period(wd_sel_ff) - 32'h1);  // R5 R6

	// any brown-out or expiry restarts the full release delay
	always_comb begin
		nxt_rst_cnt = rst_cnt_ff;
		if (low_s || wd_expire) begin
			nxt_rst_cnt = '0;  // R10 R5
		end else if (rst_act) begin
			nxt_rst_cnt = rst_cnt_ff + 32'h1;  // R11
		end
		nxt_reset_out = (nxt_rst_cnt != POR_CYCLES);
		// held at zero in reset so the host gets a full period after release
		if (!wd_en || rst_act || cs_fall || wd_expire) begin
			nxt_wd_cnt = '0;  // R4 R17
		end else begin
			nxt_wd_cnt = wd_cnt_ff + 32'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rst_cnt_ff   <= '0;
			reset_out_ff <= 1'b1;  // R11
			wd_cnt_ff    <= '0;
		end else begin
			rst_cnt_ff   <= nxt_rst_cnt;
			reset_out_ff <= nxt_reset_out;
			wd_cnt_ff    <= nxt_wd_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial port and status register

	ser_state_t  st_ff;
	ser_state_t  nxt_st;
	logic [2:0]  bit_ff;
	logic [2:0]  nxt_bit;
	logic [7:0]  in_sh_ff;
	logic [7:0]  nxt_in_sh;
	logic [7:0]  out_sh_ff;
	logic [7:0]  nxt_out_sh;
	logic [7:0]  wr_data_ff;
	logic [7:0]  nxt_wr_data;
	logic [31:0] wip_cnt_ff;
	logic [31:0] nxt_wip_cnt;
	logic [1:0]  nxt_wd_sel;
	logic [1:0]  bl_ff;
	logic [1:0]  nxt_bl;
	logic        protect_lock_enable_bit_ff;
	logic        nxt_protect_lock_enable_bit;
	logic        flag_ff;
	logic        nxt_flag;
	logic        wel_ff;
	logic        nxt_wel;
	logic        wip_ff;
	logic        nxt_wip;
	logic        pend_ff;
	logic        nxt_pend;
	logic        so_ff;
	logic        nxt_so;
	logic        so_oe_ff;
	logic        nxt_so_oe;
	logic        standby_ff;
	logic        nxt_standby;
	logic        locked;
	logic [7:0]  op_now;
	logic [7:0]  status;

	assign locked = protect_lock_enable_bit_ff && !wp_n_s;  // R9
	assign op_now = {in_sh_ff[6:0], si_s};  // R13
	assign status = {protect_lock_enable_bit_ff, flag_ff, wd_sel_ff, bl_ff, wel_ff, wip_ff};

	// frame sequencing, instruction decode and status updates
	always_comb begin
		nxt_st      = st_ff;
		nxt_bit     = bit_ff;
		nxt_in_sh   = in_sh_ff;
		nxt_out_sh  = out_sh_ff;
		nxt_wr_data = wr_data_ff;
		nxt_wip_cnt = wip_cnt_ff;
		nxt_wd_sel  = wd_sel_ff;
		nxt_bl      = bl_ff;
		nxt_protect_lock_enable_bit    = protect_lock_enable_bit_ff;
		nxt_flag    = flag_ff;
		nxt_wel     = wel_ff;
		nxt_wip     = wip_ff;
		nxt_pend    = pend_ff;
		nxt_so      = so_ff;
		// self-timed nonvolatile write; latch drops when it ends
		if (wip_ff) begin
			if (wip_cnt_ff == NVW_CYCLES - 32'h1) begin
				nxt_wip     = 1'b0;
				nxt_wel     = 1'b0;
				nxt_wip_cnt = '0;
			end else begin
				nxt_wip_cnt = wip_cnt_ff + 32'h1;
			end
		end
		// in reset no frame opens, decodes or commits; a pending write is abandoned
		if (rst_act) begin
			nxt_st   = SER_IDLE;  // R12
			nxt_pend = 1'b0;
		end else if (cs_fall) begin  // a level at power-up opens nothing
			nxt_st  = SER_OPCODE;  // R1 R2
			nxt_bit = '0;
		end else if (cs_rise) begin
			nxt_st = SER_IDLE;
			if (pend_ff) begin
				nxt_pend    = 1'b0;
				nxt_flag    = wr_data_ff[ST_FLAG];  // R16
				nxt_wip     = 1'b1;
				nxt_wip_cnt = '0;
				if (!locked) begin
					nxt_protect_lock_enable_bit   = wr_data_ff[ST_PROTECT_LOCK_ENABLE_BIT];
					nxt_wd_sel = wr_data_ff[ST_WD_HI:ST_WD_LO];  // R8 R9
					nxt_bl     = wr_data_ff[ST_BL_HI:ST_BL_LO];
				end
			end
		end else if (sck_rise && st_ff != SER_IDLE) begin
			nxt_in_sh = op_now;  // R13
			nxt_bit   = bit_ff + 3'h1;
			if (bit_ff == BIT_LAST && st_ff == SER_WRDATA) begin
				nxt_wr_data = op_now;
				nxt_pend    = 1'b1;
				nxt_st      = SER_IGNORE;
			end else if (bit_ff == BIT_LAST && st_ff == SER_OPCODE) begin
				nxt_st = SER_IGNORE;
				// a busy write accepts nothing but a status read
				if (!wip_ff || op_now == OP_RDSR) begin
					case (op_now)
						OP_WREN:     nxt_wel = 1'b1;
						OP_SET_FLAG: nxt_flag = 1'b1;  // R16
						OP_CLR: begin
							nxt_wel  = 1'b0;
							nxt_flag = 1'b0;  // R16
						end
						OP_RDSR: begin
							nxt_out_sh = status;
							nxt_st     = SER_RDOUT;
						end
						OP_WRSR: nxt_st = wel_ff ? SER_WRDATA : SER_IGNORE;
						// memory array is not present: reads and writes fall through
						default: nxt_st = SER_IGNORE;
					endcase
				end
			end
		end else if (sck_fall && st_ff == SER_RDOUT) begin
			nxt_so     = out_sh_ff[7];  // R14
			nxt_out_sh = {out_sh_ff[6:0], out_sh_ff[7]};
		end
		nxt_so_oe   = (nxt_st == SER_RDOUT) && !cs_s;  // R1
		nxt_standby = cs_s && !nxt_wip;  // R3
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff      <= SER_IDLE;
			bit_ff     <= '0;
			in_sh_ff   <= '0;
			out_sh_ff  <= '0;
			wr_data_ff <= '0;
			wip_cnt_ff <= '0;
			wd_sel_ff  <= WD_SEL_RST;
			bl_ff      <= BL_RST;
			protect_lock_enable_bit_ff    <= PROTECT_LOCK_ENABLE_BIT_RST;
			flag_ff    <= 1'b0;  // R16
			wel_ff     <= 1'b0;
			wip_ff     <= 1'b0;
			pend_ff    <= 1'b0;
			so_ff      <= 1'b0;
			so_oe_ff   <= 1'b0;
			standby_ff <= 1'b1;
		end else begin
			st_ff      <= nxt_st;
			bit_ff     <= nxt_bit;
			in_sh_ff   <= nxt_in_sh;
			out_sh_ff  <= nxt_out_sh;
			wr_data_ff <= nxt_wr_data;
			wip_cnt_ff <= nxt_wip_cnt;
			wd_sel_ff  <= nxt_wd_sel;
			bl_ff      <= nxt_bl;
			protect_lock_enable_bit_ff    <= nxt_protect_lock_enable_bit;
			flag_ff    <= nxt_flag;
			wel_ff     <= nxt_wel;
			wip_ff     <= nxt_wip;
			pend_ff    <= nxt_pend;
			so_ff      <= nxt_so;
			so_oe_ff   <= nxt_so_oe;
			standby_ff <= nxt_standby;
		end
	end

	// outputs straight from flops
	assign reset_out               = reset_out_ff;
	assign so_out                  = so_ff;
	assign so_oe                   = so_oe_ff;
	assign standby                 = standby_ff;
	assign reset_cause_flag        = flag_ff;
	assign timeout_select_high_bit = wd_sel_ff[1];
	assign timeout_select_low_bit  = wd_sel_ff[0];

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	chk_so_float: assert property (cs_s |=> !so_oe_ff)  // R1
		else $error("serial output driven while deselected");
	chk_standby_idle: assert property (cs_s && !wip_ff && !pend_ff |=> standby_ff)  // R3
		else $error("no standby while deselected and idle");
	chk_busy_active: assert property (wip_ff ##1 wip_ff |-> !standby_ff)  // R3
		else $error("standby during nonvolatile write");
	chk_kick_restart: assert property (cs_fall |=> wd_cnt_ff == '0)  // R4
		else $error("falling select did not restart watchdog");
	chk_wd_expiry: assert property (wd_expire && !low_s |=> reset_out_ff && rst_cnt_ff == '0)  // R5
		else $error("expiry did not assert reset");
	chk_wd_disabled: assert property (!wd_en |=> wd_cnt_ff == '0 && !wd_expire)  // R6
		else $error("disabled watchdog counting");
	chk_lock_holds: assert property (locked |=> $stable({protect_lock_enable_bit_ff, wd_sel_ff, bl_ff}))  // R9
		else $error("locked bits changed");
	chk_brownout: assert property (low_s |=> reset_out_ff [*2])  // R10
		else $error("brown-out did not hold reset");
	chk_release_delay: assert property ($fell(reset_out_ff) |-> $past(rst_cnt_ff) == POR_CYCLES - 1)  // R11
		else $error("reset released before full delay");
	chk_reset_ignore: assert property (rst_act |=> st_ff == SER_IDLE && $stable(flag_ff))  // R12
		else $error("instruction taken during reset");
	chk_so_on_fall: assert property (so_ff != $past(so_ff) |-> $past(sck_fall))  // R14
		else $error("serial output moved off a falling edge");
	chk_flag_set: assert property (sck_rise && st_ff == SER_OPCODE && bit_ff == BIT_LAST
		&& op_now == OP_SET_FLAG && !wip_ff && !rst_act && !cs_rise |=> flag_ff)  // R16
		else $error("set flag command ignored");
	chk_wd_restart: assert property ($fell(reset_out_ff) |-> wd_cnt_ff == '0)  // R17
		else $error("watchdog count not fresh after reset");

	cov_wd_reset:    cover property (wd_expire);
	cov_status_read: cover property (st_ff == SER_RDOUT && sck_fall);
	cov_status_wr:   cover property (cs_rise && pend_ff && !rst_act);
	cov_release:     cover property ($fell(reset_out_ff));

endmodule : sup_watchdog

// ==== tb/host_model.sv ====
// behavioural host: drives select, serial clock and data, samples the reply
`timescale 1ns/10ps
module host_model (
	// serial pins towards the device
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	// reply line, already resolved by the bench
	input  wire logic so_line
);
	// idle: deselected, clock parked low outside frames
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// bare select level, used for watchdog kicks
	task automatic sel(input logic lvl);
		cs_n = lvl;
	endtask : sel

	// one frame, msb first; the 160 ns clock runs only while selected
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		#20 cs_n = 1'b0;
		#200;
		for (int i = nbits - 1; i >= 0; i--) begin
			si = tx[i];
			#80 sck = 1'b1;
			rx[i] = so_line;
			#80 sck = 1'b0;
		end
		si = ~si; // stale data must not look held
		#100 cs_n = 1'b1;
		#200;
	endtask : xfer
endmodule : host_model

// ==== tb/tb.sv ====
// self-checking bench for the supervisor, host model on the serial side
`timescale 1ns/10ps
module tb;
	import sup_pkg::*;
	localparam int POR = 200;
	localparam int NVW = 50;
	localparam int PER [4] = '{1200, 800, 400, 0};

	logic       ref_clk, srst, wp_n, supply_low, cs_n, sck, si;
	logic       so_out, so_oe, so_line, reset_out, standby, flag, wd_hi, wd_lo;
	logic       lockb, fl;
	logic [1:0] wd, bl, s;
	logic [7:0] d;
	int         n_fail, total_checks, seed;

	sup_watchdog #(.POR_CYCLES(POR), .WD_LONG_CYCLES(PER[0]), .WD_MID_CYCLES(PER[1]),
		.WD_SHORT_CYCLES(PER[2]), .NVW_CYCLES(NVW)) dut (
		.ref_clk(ref_clk), .srst(srst), .select_and_kick_input_n(cs_n), .sck(sck),
		.si(si), .so_out(so_out), .so_oe(so_oe), .write_protect_n(wp_n),
		.supply_low(supply_low), .reset_out(reset_out), .standby(standby),
		.reset_cause_flag(flag), .timeout_select_high_bit(wd_hi),
		.timeout_select_low_bit(wd_lo));
	host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so_line(so_line));

	////////////////////////////////////////////////////////////////////////
	// 50 MHz clock; released output line shows the inverse of its last bit, not old data
	always #10 ref_clk = ~ref_clk;
	assign so_line = so_oe ? so_out : ~so_out;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// inputs always change 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic wait_low(input int lim);
		int k;
		k = 0;
		while (reset_out !== 1'b0) begin
			cyc(1);
			k++;
			if (k > lim) begin
				n_fail++;
				final_report();
			end
		end
	endtask : wait_low

	// expected status byte; latch and busy are idle whenever this is read
	function automatic logic [7:0] stat();
		return {lockb, fl, wd, bl, 2'b00};
	endfunction : stat

	task automatic op(input logic [7:0] code);
		logic [15:0] r;
		host.xfer({8'h00, code}, 8, r);
	endtask : op

	task automatic rdsr;
		logic [15:0] r;
		host.xfer({OP_RDSR, 8'h00}, 16, r);
		check(r[7:0], stat());
		check(so_oe, 1'b0);
	endtask : rdsr

	// lock is judged with the old lock bit, as the commit sees it
	task automatic wrsr(input logic [7:0] v);
		logic [15:0] r;
		op(OP_WREN);
		op(OP_WRSR);
		host.xfer({OP_WRSR, v}, 16, r);
		check(standby, 1'b0);
		cyc(NVW + 10);
		check(standby, 1'b1);
		fl = v[6];
		if (!(lockb && !wp_n)) {lockb, wd, bl} = {v[7], v[5:2]};
		check({wd_hi, wd_lo}, wd);
	endtask : wrsr

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		wp_n = 1'b1;
		supply_low = 1'b0;
		n_fail = 0;
		total_checks = 0;
		seed = 32'h9b69;
		{lockb, fl, wd, bl} = {2'b00, WD_SEL_OFF, BL_RST};
		cyc(3);
		srst = 1'b0;
		cyc(POR - 10);
		check(reset_out, 1'b1);
		check(standby, 1'b1);
		wait_low(30);
		rdsr();
		// cause flag set and cleared by command
		op(OP_SET_FLAG);
		fl = 1'b1;
		check(flag, 1'b1);
		rdsr();
		op(OP_CLR);
		fl = 1'b0;
		check(flag, 1'b0);
		// lock bit with protect pin low freezes the select bits
		wp_n = 1'b0;
		wrsr(8'hb0);
		wrsr(8'h94);
		check({wd_hi, wd_lo}, WD_SEL_OFF);
		rdsr();
		wp_n = 1'b1;
		wrsr(8'h30);
		// every select code, select held high on even passes, low on odd
		for (int i = 0; i < 4; i++) begin
			host.sel(1'b1);
			cyc(5);
			s = 2'(i + 3);
			d = 8'($random(seed));
			// random protect pin; lock bit stays clear so nothing may freeze
			wp_n = d[7];
			wrsr({1'b0, d[6], s, d[3:0]});
			rdsr();
			host.sel(1'b0);
			cyc(6);
			check(standby, 1'b0);
			if (!i[0]) host.sel(1'b1);
			if (s == WD_SEL_OFF) begin
				cyc(PER[0] + 100);
				check(reset_out, 1'b0);
			end else begin
				cyc(PER[s] - 16);
				check(reset_out, 1'b0);
				cyc(26);
				check(reset_out, 1'b1);
				check(flag, fl);
				wait_low(POR + 40);
				cyc(PER[s] - 20);
				check(reset_out, 1'b0);
				cyc(40);
				wait_low(POR + 40);
			end
		end
		// regular kicks inside the shortest period keep reset away
		host.sel(1'b1);
		for (int i = 0; i < 12; i++) begin
			host.sel(1'b0);
			cyc(6);
			host.sel(1'b1);
			cyc(100 + ($unsigned($random(seed)) % 81));
			check(reset_out, 1'b0);
		end
		// brown-out: instructions ignored while reset is held
		op(OP_CLR);
		fl = 1'b0;
		supply_low = 1'b1;
		cyc(8);
		check(reset_out, 1'b1);
		op(OP_SET_FLAG);
		supply_low = 1'b0;
		cyc(POR - 10);
		check(reset_out, 1'b1);
		wait_low(40);
		check(flag, 1'b0);
		final_report();
	end
endmodule : tb
